// ===== design/flash_pin_map.svh
// Purpose: Widths, lane masks, reset values and timing counts of the flash pin front end.
// Assumes: Core clock of 125 MHz.
// Notes: Definitions only.
`ifndef FLASH_PIN_MAP_SVH
`define FLASH_PIN_MAP_SVH

`define FP_CLK_PERIOD_NS 8
`define FP_RESET_TIME_NS 1000
`define FP_RESET_CYCLES ((`FP_RESET_TIME_NS + `FP_CLK_PERIOD_NS - 1) / `FP_CLK_PERIOD_NS)
`define FP_RST_CNT_W 12
`define FP_LINES 4
`define FP_BYTE_W 8
`define FP_MASK_SINGLE 4'h2
`define FP_MASK_DUAL 4'h3
`define FP_MASK_QUAD 4'hf
`define FP_SYNC_INIT 7'h1f

`endif

// ===== design/flash_pin_pkg.sv
// Purpose: Types shared by the flash pin front end and its user.
// Assumes: Nothing beyond the map header.
// Notes: Lane width codes are chosen by the core per instruction phase.
`default_nettype none
package flash_pin_pkg;

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'b00,
    LANE_DUAL = 2'b01,
    LANE_QUAD = 2'b10
  } lane_width_t;

  typedef enum logic [1:0] {
    LNK_IDLE = 2'b00,
    LNK_ACTIVE = 2'b01,
    LNK_HELD = 2'b10,
    LNK_RESET = 2'b11
  } link_state_t;

  typedef struct packed {
    lane_width_t width;
    logic drive;
  } lane_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } rx_word_t;

endpackage
`default_nettype wire

// ===== design/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of pins.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage leaves the module.
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Pins and synchronised copy
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_q <= INIT[g];
          stable_q <= INIT[g];
        end else begin
          meta_q <= pin_i[g];
          stable_q <= meta_q;
        end
      end
      assign sync_o[g] = stable_q;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== design/flash_pin_front.sv
// Purpose: Pin front end of a serial NOR flash: select, edges, lane mapping, protect, hold, reset pin.
// Assumes: Serial clock well below an eighth of the core clock, since all pins are oversampled.
// Notes: The instruction decoder sits outside and steers lane width and drive per phase.
//
// Overview of operation
// - Chip select high deselects the device and floats every data line.
// - A running internal erase, program or status write survives deselect.
// - Chip select low selects the device for instruction input and read output.
// - Nothing is accepted until a chip select falling edge follows power-up.
// - Single-line input bits are sampled from serial_in on rising serial clock.
// - Single-line output changes on line one at falling serial clock.
// - Dual and quad lines capture on rising and drive on falling edges.
// - Single and dual use lines zero and one; quad uses all four.
// - Quad needs quad_enable_bit; lines two and three then carry data.
// - Write-protect is active low and blocks status register writes.
// - Write-protect with protect bits locks any region, sector up to array; here it only blocks status writes.
// - Hold low while selected floats output and ignores clock and input.
// - Releasing hold resumes the transfer exactly where it paused; output stays floated until the next falling serial clock.
// - With quad_enable_bit set the hold function is disabled.
// - The reset pin resets regardless of configuration and state.
// - Reset pin low about one microsecond aborts all and restores power-on state.
// - SPI modes 0 and 3 both work, clock idle level irrelevant.
`default_nettype none
`include "flash_pin_map.svh"
module flash_pin_front
  import flash_pin_pkg::*;
#(
  parameter int RESET_CYCLES = `FP_RESET_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Flash pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic hw_reset_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // Configuration from the status bits
  input wire logic quad_enable_bit_i,
  input wire logic status_protect_bit_i,
  // Lane control and data toward the decoder
  input wire lane_cfg_t lane_cfg_i,
  input wire logic [3:0] tx_bits_i,
  output logic tx_take_o,
  output rx_word_t rx_o,
  // Internal operation tracking
  input wire logic start_op_i,
  input wire logic op_done_i,
  output logic op_busy_o,
  // Status
  output logic selected_o,
  output link_state_t link_state_o,
  output logic status_write_allow_o,
  output logic protect_locked_o,
  output logic quad_refused_o,
  output logic hw_reset_o
);

  logic cs_s;
  logic sclk_s;
  logic rpin_s;
  logic [3:0] io_s;

  // Chip select syncs from low so that a fall is only seen after a real high.
  // Reset pin and data lines sync from their idle high, so no count or hold follows reset.
  pin_sync #(
    .W(7),
    .INIT(`FP_SYNC_INIT)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i({cs_n_i, sclk_i, hw_reset_n_i, io_i}),
    .sync_o({cs_s, sclk_s, rpin_s, io_s})
  );

  function automatic logic [3:0] lane_mask(input lane_width_t w);
    case (w)
      LANE_SINGLE: lane_mask = `FP_MASK_SINGLE;
      LANE_DUAL: lane_mask = `FP_MASK_DUAL;
      LANE_QUAD: lane_mask = `FP_MASK_QUAD;
      default: lane_mask = 4'h0;
    endcase
  endfunction

  logic cs_prev_q, cs_prev_d;
  logic sclk_prev_q, sclk_prev_d;
  logic armed_q, armed_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  rx_word_t rx_q, rx_d;
  logic [3:0] io_q, io_d;
  logic [3:0] oe_q, oe_d;
  logic busy_q, busy_d;
  logic [`FP_RST_CNT_W-1:0] rcnt_q, rcnt_d;
  logic rst_hit_q, rst_hit_d;
  link_state_t state_q, state_d;
  logic allow_q, allow_d;
  logic qref_q, qref_d;

  logic sel, hold_act, lanes_ok, run, rise, fall, cs_fall, wp_low, drive_ok;
  logic [3:0] step;
  logic [3:0] sum;

  always_comb begin
    sel = !cs_s;
    hold_act = sel && !quad_enable_bit_i && !io_s[3];
    lanes_ok = !(lane_cfg_i.width == LANE_QUAD && !quad_enable_bit_i);
    run = sel && armed_q && !hold_act && !rst_hit_q && lanes_ok;
    rise = sclk_s && !sclk_prev_q;
    fall = !sclk_s && sclk_prev_q;
    cs_fall = cs_prev_q && !cs_s;
    wp_low = !quad_enable_bit_i && !io_s[2];
    drive_ok = sel && !hold_act && !rst_hit_q && lane_cfg_i.drive && lanes_ok;
    case (lane_cfg_i.width)
      LANE_DUAL: step = 4'h2;
      LANE_QUAD: step = 4'h4;
      default: step = 4'h1;
    endcase
    sum = {1'b0, cnt_q} + step;

    cs_prev_d = cs_s;
    sclk_prev_d = sclk_s;
    armed_d = armed_q || cs_fall;
    cnt_d = cnt_q;
    shift_d = shift_q;
    rx_d = '0;
    io_d = io_q;
    oe_d = oe_q;
    tx_take_o = 1'b0;
    // Counters restart at every select edge, so modes 0 and 3 line up alike.
    if (cs_fall || !sel) begin
      cnt_d = 3'h0;
    end else if (run && rise) begin
      cnt_d = sum[2:0];
      case (lane_cfg_i.width)
        LANE_DUAL: shift_d = {shift_q[5:0], io_s[1:0]};
        LANE_QUAD: shift_d = {shift_q[3:0], io_s};
        default: shift_d = {shift_q[6:0], io_s[0]};
      endcase
      rx_d.valid = sum[3];
      rx_d.data = shift_d;
    end
    if (run && fall && lane_cfg_i.drive) begin
      tx_take_o = 1'b1;
      io_d = (lane_cfg_i.width == LANE_SINGLE) ? {2'b00, tx_bits_i[0], 1'b0} : tx_bits_i;
      oe_d = lane_mask(lane_cfg_i.width);
    end else if (!drive_ok) begin
      oe_d = 4'h0;
    end

    busy_d = busy_q;
    if (start_op_i) begin
      busy_d = 1'b1;
    end else if (op_done_i) begin
      busy_d = 1'b0;
    end

    rcnt_d = '0;
    rst_hit_d = 1'b0;
    if (!rpin_s) begin
      rcnt_d = rst_hit_q ? rcnt_q : rcnt_q + `FP_RST_CNT_W'(1);
      rst_hit_d = rst_hit_q || (rcnt_q == `FP_RST_CNT_W'(RESET_CYCLES - 1));
    end
    if (rst_hit_q) begin
      armed_d = 1'b0;
      busy_d = 1'b0;
      cnt_d = 3'h0;
      oe_d = 4'h0;
    end

    state_d = state_q;
    case (state_q)
      LNK_RESET: begin
        // Leave only once the pin has let go; arming is gone then, so idle comes next.
        if (!rst_hit_q) begin
          state_d = LNK_IDLE;
        end
      end
      LNK_IDLE, LNK_ACTIVE, LNK_HELD: begin
        if (rst_hit_q) begin
          state_d = LNK_RESET;
        end else if (!sel) begin
          state_d = LNK_IDLE;
        end else if (hold_act) begin
          state_d = LNK_HELD;
        end else if (armed_q) begin
          state_d = LNK_ACTIVE;
        end else begin
          state_d = LNK_IDLE;
        end
      end
      default: begin
        state_d = LNK_IDLE;
      end
    endcase

    allow_d = !(status_protect_bit_i && wp_low);
    qref_d = sel && !lanes_ok;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      armed_q <= 1'b0;
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      rx_q <= '0;
      io_q <= 4'h0;
      oe_q <= 4'h0;
      busy_q <= 1'b0;
      rcnt_q <= '0;
      rst_hit_q <= 1'b0;
      state_q <= LNK_IDLE;
      allow_q <= 1'b1;
      qref_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_prev_d;
      sclk_prev_q <= sclk_prev_d;
      armed_q <= armed_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      rx_q <= rx_d;
      io_q <= io_d;
      oe_q <= oe_d;
      busy_q <= busy_d;
      rcnt_q <= rcnt_d;
      rst_hit_q <= rst_hit_d;
      state_q <= state_d;
      allow_q <= allow_d;
      qref_q <= qref_d;
    end
  end

  // The gate is combinational so that deselect or hold floats the lines at once.
  assign io_oe_o = oe_q & {4{drive_ok}};
  assign io_o = io_q;
  assign rx_o = rx_q;
  assign op_busy_o = busy_q;
  assign selected_o = sel;
  assign link_state_o = state_q;
  assign status_write_allow_o = allow_q;
  assign protect_locked_o = !allow_q;
  assign quad_refused_o = qref_q;
  assign hw_reset_o = rst_hit_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_desel_float: assert property (cs_s |-> io_oe_o == 4'h0)
    else $error("data line driven while deselected");
  chk_busy_survives: assert property (busy_q && cs_fall == 1'b0 && !op_done_i && !rst_hit_q |=> busy_q)
    else $error("internal operation dropped without done");
  chk_select_state: assert property (sel && armed_q && !hold_act && !rst_hit_q |=> state_q == LNK_ACTIVE)
    else $error("selected device not active");
  chk_power_arm: assert property (!armed_q |=> !rx_q.valid)
    else $error("byte accepted before first select fall");
  chk_rise_capture: assert property (cnt_q != $past(cnt_q)
    && !$past(cs_fall) && !$past(cs_s) && !$past(rst_hit_q) |-> $past(rise) && $past(run))
    else $error("bit counted off a rising edge");
  chk_fall_drive: assert property ($changed(io_q) |-> $past(fall) && $past(lane_cfg_i.drive))
    else $error("output changed off a falling edge");
  chk_lane_width: assert property ((io_oe_o & ~lane_mask(lane_cfg_i.width)) == 4'h0
    || $changed(lane_cfg_i))
    else $error("line outside lane width driven");
  chk_quad_gate: assert property (lane_cfg_i.width == LANE_QUAD && !quad_enable_bit_i
    |-> io_oe_o == 4'h0 && !tx_take_o)
    else $error("quad honoured without enable");
  chk_wp_block: assert property (status_protect_bit_i && wp_low
    |=> !status_write_allow_o && protect_locked_o)
    else $error("status write allowed under write protect");
  chk_hold_float: assert property (hold_act |-> io_oe_o == 4'h0 && !tx_take_o)
    else $error("output active during hold");
  chk_hold_resume: assert property (hold_act && !rst_hit_q ##1 hold_act
    |-> $stable(cnt_q) && $stable(shift_q))
    else $error("position lost during hold");
  chk_qe_no_hold: assert property (quad_enable_bit_i
    |-> !hold_act && state_q != LNK_HELD || !$past(quad_enable_bit_i))
    else $error("hold active with quad enable set");
  chk_reset_time: assert property ($rose(rst_hit_q)
    |-> !$past(rpin_s) && $past(rcnt_q) == `FP_RST_CNT_W'(RESET_CYCLES - 1))
    else $error("reset pin acted before its time");
  chk_reset_abort: assert property (rst_hit_q |=> !busy_q && !armed_q && io_oe_o == 4'h0)
    else $error("reset pin did not restore power-on state");
  chk_mode_restart: assert property (cs_fall |=> cnt_q == 3'h0)
    else $error("bit count not restarted on select");
  chk_reset_hold: assert property (rst_hit_q && !rpin_s |=> rst_hit_q)
    else $error("reset pin released its hold early");
  chk_input_phase: assert property (!lane_cfg_i.drive |-> io_oe_o == 4'h0)
    else $error("data line driven in an input phase");
  chk_held_state: assert property (hold_act && !rst_hit_q && state_q != LNK_RESET |=> state_q == LNK_HELD)
    else $error("hold not reported");
  chk_byte_edge: assert property (rx_q.valid |-> $past(run) && $past(rise))
    else $error("byte completed off a rising edge");
  chk_quad_flag: assert property (sel && !lanes_ok |=> quad_refused_o)
    else $error("refused quad phase not flagged");

  cov_byte_in: cover property (armed_q ##1 rx_q.valid);
  cov_quad_out: cover property (tx_take_o && lane_cfg_i.width == LANE_QUAD);
  cov_hold: cover property (hold_act ##1 !hold_act && sel);
  cov_hw_reset: cover property (busy_q ##1 rst_hit_q);
  cov_mode3_sel: cover property (cs_fall && sclk_s);

endmodule
`default_nettype wire

// ===== testbench/spi_host_model.sv
// Purpose: Behavioural host controller that drives select, serial clock and the four data lines.
// Assumes: Called from the bench at falling core clock edges; half serial period is five core cycles.
// Notes: Lines two and three are pulled up when released; lines zero and one then toggle every cycle.
`default_nettype none
module spi_host_model (
  // Core clock used for pacing and for the toggling of released lines zero and one
  input wire logic core_clk_i,
  // Device side of the data lines
  input wire logic [3:0] dev_io_i,
  input wire logic [3:0] dev_oe_i,
  // Pins toward the device
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] drv_q = 4'h0;
  logic [3:0] val_q = 4'h0;
  logic [3:0] last_q = 4'h0;
  logic idle_q = 1'b0;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end

  // A released line zero or one must not keep its last level, or a lost bit could still look right.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line_o[i] = dev_oe_i[i] ? dev_io_i[i] : drv_q[i] ? val_q[i] : (i > 1) ? 1'b1 : ~last_q[i];
    end
  end

  always_ff @(posedge core_clk_i) last_q <= line_o;

  task automatic half();
    repeat (5) @(negedge core_clk_i);
  endtask

  task automatic pin(input logic [3:0] d, input logic [3:0] v);
    drv_q = d;
    val_q = v;
  endtask

  // The clock settles at its idle level before the select edge.
  task automatic sel(input logic cpol);
    idle_q = cpol;
    sclk_o = cpol;
    half();
    cs_n_o = 1'b0;
    half();
  endtask

  task automatic desel();
    sclk_o = idle_q;
    half();
    cs_n_o = 1'b1;
    drv_q = 4'h0;
    half();
  endtask

  // Data changes while the clock is low and is held across the rising edge.
  task automatic shift(input int lanes, input int nbits, input logic [7:0] b);
    for (int k = nbits - lanes; k >= 0; k -= lanes) begin
      sclk_o = 1'b0;
      for (int j = 0; j < lanes; j++) begin
        drv_q[j] = 1'b1;
        val_q[j] = b[k + j];
      end
      half();
      sclk_o = 1'b1;
      half();
    end
  endtask

  task automatic pulse();
    sclk_o = 1'b1;
    half();
    sclk_o = 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the flash pin front end.
// Assumes: Reset pin count shortened to 8 cycles.
// Notes: Lane cases run from a table; reset, hold, protect and busy are written out.
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch at %0t got %0h expected %0h", $time, got, exp); end end
module tb_top
  import flash_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {lane_width_t w; logic qe; logic cpol; logic [7:0] b; int nrx; logic [3:0] oe;} row_t;
  logic core_clk, rst_n, cs_n, sclk, hw_reset_n, qe, sp, tx_take, start_op, op_done, op_busy;
  logic selected, swa, locked, quad_refused, hw_reset;
  logic [3:0] io_i, io_o, io_oe, tx_bits;
  lane_cfg_t lane_cfg;
  rx_word_t rx;
  link_state_t link_state;
  int error_cnt = 0;
  int n_checks = 0;
  int rx_cnt = 0;
  int tx_cnt = 0;
  int cyc = 0;
  logic [7:0] rx_last;
  row_t rows [4];

  flash_pin_front #(.RESET_CYCLES(8)) u_flash_pin_front (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .cs_n_i(cs_n), .sclk_i(sclk), .hw_reset_n_i(hw_reset_n), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe),
    .quad_enable_bit_i(qe), .status_protect_bit_i(sp), .lane_cfg_i(lane_cfg), .tx_bits_i(tx_bits),
    .tx_take_o(tx_take), .rx_o(rx), .start_op_i(start_op), .op_done_i(op_done), .op_busy_o(op_busy),
    .selected_o(selected), .link_state_o(link_state), .status_write_allow_o(swa),
    .protect_locked_o(locked), .quad_refused_o(quad_refused), .hw_reset_o(hw_reset));

  spi_host_model u_spi_host_model (.core_clk_i(core_clk), .dev_io_i(io_o), .dev_oe_i(io_oe),
    .cs_n_o(cs_n), .sclk_o(sclk), .line_o(io_i));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (rx.valid === 1'b1) begin
      rx_cnt++;
      rx_last = rx.data;
    end
    if (tx_take === 1'b1) begin
      tx_cnt++;
    end
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  initial begin
    int lanes;
    int n0;
    int t0;
    rst_n = 1'b0;
    hw_reset_n = 1'b1;
    {qe, sp, start_op, op_done} = 4'h0;
    lane_cfg = '{width: LANE_SINGLE, drive: 1'b0};
    tx_bits = 4'h5;
    rows[0] = '{LANE_SINGLE, 1'b0, 1'b0, 8'ha5, 1, 4'h2};
    rows[1] = '{LANE_DUAL, 1'b0, 1'b1, 8'h3c, 1, 4'h3};
    rows[2] = '{LANE_QUAD, 1'b1, 1'b0, 8'hc3, 1, 4'hf};
    rows[3] = '{LANE_QUAD, 1'b0, 1'b1, 8'h96, 0, 4'h0};
    // Select falls inside reset, so the device has seen no select edge afterwards.
    u_spi_host_model.sel(1'b0);
    wait_n(6);
    rst_n = 1'b1;
    `CHK(io_oe, 4'h0)
    `CHK(swa, 1'b1)
    wait_n(4);
    u_spi_host_model.shift(1, 8, 8'h5a);
    wait_n(8);
    `CHK(rx_cnt, 0)
    u_spi_host_model.desel();
    foreach (rows[i]) begin
      lanes = (rows[i].w == LANE_QUAD) ? 4 : (rows[i].w == LANE_DUAL) ? 2 : 1;
      qe = rows[i].qe;
      lane_cfg = '{width: rows[i].w, drive: 1'b0};
      n0 = rx_cnt;
      u_spi_host_model.sel(rows[i].cpol);
      `CHK(selected, 1'b1)
      u_spi_host_model.shift(lanes, 8, rows[i].b);
      wait_n(8);
      `CHK(rx_cnt - n0, rows[i].nrx)
      if (rows[i].nrx == 1) `CHK(rx_last, rows[i].b)
      `CHK(quad_refused, rows[i].nrx == 0)
      // The host lets go of every line before the output phase.
      u_spi_host_model.pin(4'h0, 4'h0);
      t0 = tx_cnt;
      lane_cfg = '{width: rows[i].w, drive: 1'b1};
      u_spi_host_model.pulse();
      `CHK(io_oe, rows[i].oe)
      if (lanes == 1) `CHK(io_o[1], 1'b1)
      `CHK(tx_cnt - t0, rows[i].nrx)
      u_spi_host_model.desel();
      `CHK(io_oe, 4'h0)
      lane_cfg = '{width: LANE_SINGLE, drive: 1'b0};
    end
    qe = 1'b0;
    n0 = rx_cnt;
    u_spi_host_model.sel(1'b0);
    u_spi_host_model.shift(1, 4, 8'h0b);
    u_spi_host_model.pin(4'h8, 4'h0);
    u_spi_host_model.shift(1, 4, 8'h0f);
    `CHK(link_state, LNK_HELD)
    u_spi_host_model.pin(4'h0, 4'h0);
    u_spi_host_model.shift(1, 4, 8'h04);
    wait_n(8);
    `CHK(rx_cnt - n0, 1)
    `CHK(rx_last, 8'hb4)
    u_spi_host_model.desel();
    sp = 1'b1;
    u_spi_host_model.pin(4'h4, 4'h0);
    wait_n(6);
    `CHK(swa, 1'b0)
    `CHK(locked, 1'b1)
    qe = 1'b1;
    wait_n(6);
    `CHK(swa, 1'b1)
    u_spi_host_model.pin(4'h0, 4'h0);
    {qe, sp} = 2'b00;
    start_op = 1'b1;
    wait_n(1);
    start_op = 1'b0;
    wait_n(4);
    `CHK(op_busy, 1'b1)
    op_done = 1'b1;
    wait_n(1);
    op_done = 1'b0;
    wait_n(2);
    `CHK(op_busy, 1'b0)
    start_op = 1'b1;
    wait_n(1);
    start_op = 1'b0;
    u_spi_host_model.sel(1'b0);
    `CHK(op_busy, 1'b1)
    hw_reset_n = 1'b0;
    wait_n(14);
    `CHK(hw_reset, 1'b1)
    `CHK(op_busy, 1'b0)
    `CHK(link_state, LNK_RESET)
    hw_reset_n = 1'b1;
    u_spi_host_model.desel();
    n0 = rx_cnt;
    u_spi_host_model.sel(1'b0);
    u_spi_host_model.shift(1, 8, 8'h69);
    wait_n(8);
    `CHK(rx_cnt - n0, 1)
    `CHK(rx_last, 8'h69)
    u_spi_host_model.desel();
    complete_run();
  end
endmodule
`default_nettype wire
